// [sim/i2c_ctrl_model.sv]
// Behavioural I2C bus controller that issues write transfers to the target
`timescale 1ns/1ps
module i2c_ctrl_model (
  // Clock that paces the controller
  input  wire logic clk_i,
  // Resolved data line
  input  wire logic sda_i,
  // Clock line and open-drain data drive, 1 releases the line
  output logic      scl_o,
  output logic      sda_o
);
  // Phase length in clocks; the target needs at least four
  int ph = 8;

  // Bus idles with both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // START from idle, or repeated START from a low clock
  task automatic start_cond();
    sda_o = 1'b1;
    gap(ph);
    scl_o = 1'b1;
    gap(ph);
    sda_o = 1'b0;
    gap(ph);
    scl_o = 1'b0;
    gap(ph);
  endtask

  // STOP, data rises while the clock is high
  task automatic stop_cond();
    sda_o = 1'b0;
    gap(ph);
    scl_o = 1'b1;
    gap(ph);
    sda_o = 1'b1;
    gap(ph);
  endtask

  // Eight bits MSB first, data changed only while the clock is low
  task automatic write_byte(input logic [7:0] b, output logic ack, output logic clash);
    clash = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sda_o = b[i];
      gap(ph);
      scl_o = 1'b1;
      gap(ph / 2);
      // A target may pull the line only in the acknowledge slot
      if (sda_i !== b[i]) clash = 1'b1;
      gap(ph - ph / 2);
      scl_o = 1'b0;
    end
    sda_o = 1'b1;
    gap(ph);
    scl_o = 1'b1;
    gap(ph / 2);
    ack = ~sda_i; // Taken mid-way through the high phase
    gap(ph - ph / 2);
    scl_o = 1'b0;
    gap(ph);
  endtask
endmodule // i2c_ctrl_model

// [sim/tb.sv]
// Self-checking testbench of the LCD driver I2C target front end
`timescale 1ns/1ps
module tb;
  import lcd_i2c_pkg::*;
  logic             clk = 1'b0;
  logic             nrst = 1'b0;
  logic             scl;
  logic             sda_drv;
  logic             sda;
  logic             sda_o;
  logic             sda_oe;
  logic             strap = 1'b0;
  logic [2:0]       pins = 3'h0;
  logic             cmd_valid;
  logic [7:0]       cmd_data;
  logic             ptr_load = 1'b0;
  logic [PTR_W-1:0] ptr_value = 6'h00;
  logic             sub_load = 1'b0;
  logic [SUB_W-1:0] sub_value = 3'h0;
  logic             ram_valid;
  logic             ram_ready = 1'b1;
  logic [PTR_W-1:0] ram_addr;
  logic [7:0]       ram_data;
  int               fail_count = 0;
  int               checks = 0;
  int               cycles = 0;
  int               cmd_pulses = 0;
  logic [13:0]      words[$];

  always #10 clk = ~clk;

  // Wired-AND data line with its pull-up
  assign sda = sda_drv & ~sda_oe;

  i2c_ctrl_model i_ctrl (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_drv));

  lcd_i2c_target i_dut (
    .CLK_I(clk), .NRST_I(nrst), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o), .SDA_OE_O(sda_oe),
    .ADDR_SELECT_STRAP_I(strap), .HW_SUBADDR_PIN_0_I(pins[0]),
    .HW_SUBADDR_PIN_1_I(pins[1]), .HW_SUBADDR_PIN_2_I(pins[2]),
    .CMD_VALID_O(cmd_valid), .CMD_DATA_O(cmd_data), .PTR_LOAD_I(ptr_load),
    .PTR_VALUE_I(ptr_value), .SUB_LOAD_I(sub_load), .SUB_VALUE_I(sub_value),
    .RAM_VALID_O(ram_valid), .RAM_READY_I(ram_ready), .RAM_ADDR_O(ram_addr),
    .RAM_DATA_O(ram_data));

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // RAM words, command pulses, open-drain output and run-time ceiling
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (ram_valid === 1'b1 && ram_ready === 1'b1) words.push_back({ram_addr, ram_data});
    if (cmd_valid === 1'b1) cmd_pulses <= cmd_pulses + 1;
    if (sda_oe === 1'b1) check("sda_o", 16'h0, {15'h0, sda_o});
    if (cycles == 40000) begin
      check("timeout", 16'h0, 16'h1);
      end_sim();
    end
  end

  task automatic put(input logic [7:0] b, input logic exp_ack);
    logic ack;
    logic clash;
    i_ctrl.write_byte(b, ack, clash);
    check("ack", {15'h0, exp_ack}, {15'h0, ack});
    check("data line", 16'h0, {15'h0, clash});
  endtask

  // Oldest word of the RAM port against the expected place and byte
  task automatic pop_word(input logic [5:0] a, input logic [7:0] d);
    logic [13:0] w;
    w = 14'bx;
    if (words.size() > 0) w = words.pop_front();
    check("ram word", {2'h0, a, d}, {2'h0, w});
  endtask

  task automatic load(input logic [5:0] p, input logic [2:0] s);
    @(negedge clk);
    ptr_load = 1'b1;
    ptr_value = p;
    sub_load = 1'b1;
    sub_value = s;
    @(negedge clk);
    ptr_load = 1'b0;
    sub_load = 1'b0;
  endtask

  // Address table under both strap levels; a refused one ignores the next byte
  task automatic t_address();
    logic [7:0] adr [5] = '{8'h70, 8'h72, 8'h71, 8'h74, 8'hf0};
    logic       hit;
    for (int s = 0; s < 2; s++) begin
      @(negedge clk);
      strap = s[0];
      for (int i = 0; i < 5; i++) begin
        hit = adr[i][7:2] == ADDR_FIXED && adr[i][1] == s[0] && !adr[i][0];
        i_ctrl.start_cond();
        put(adr[i], hit);
        put(8'h00, hit);
        i_ctrl.stop_cond();
      end
    end
    @(negedge clk);
    strap = 1'b0;
  endtask

  // Command chain, data, then a repeated START that keeps the pointer
  task automatic t_command();
    int base;
    base = cmd_pulses;
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h80, 1'b1);
    check("cmd byte", 16'h80, {8'h0, cmd_data});
    put(8'h05, 1'b1);
    check("cmd byte", 16'h05, {8'h0, cmd_data});
    put(8'h11, 1'b1);
    put(8'h22, 1'b1);
    put(8'h33, 1'b1);
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h00, 1'b1);
    put(8'h44, 1'b1);
    i_ctrl.stop_cond();
    check("cmd pulses", 16'h3, 16'(cmd_pulses - base));
    pop_word(6'h00, 8'h11);
    pop_word(6'h01, 8'h22);
    pop_word(6'h02, 8'h33);
    pop_word(6'h03, 8'h44);
  endtask

  // Subaddress gating, pointer wrap into the next subaddress
  task automatic t_subaddr();
    @(negedge clk);
    pins = 3'h5;
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h00, 1'b1);
    put(8'h55, 1'b0);
    i_ctrl.stop_cond();
    load(PTR_LAST, 3'h5);
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h00, 1'b1);
    put(8'h66, 1'b1);
    put(8'h77, 1'b0);
    i_ctrl.stop_cond();
    pins = 3'h6;
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h00, 1'b1);
    put(8'h88, 1'b1);
    i_ctrl.stop_cond();
    pop_word(PTR_LAST, 8'h66);
    pop_word(6'h01, 8'h88);
    check("word count", 16'h0, 16'(words.size()));
  endtask

  // RAM stalls until the buffer refuses, with a faster controller
  task automatic t_fifo();
    pins = 3'h0;
    ram_ready = 1'b0;
    load(PTR_RST, SUB_RST);
    i_ctrl.ph = 5;
    i_ctrl.start_cond();
    put(8'h70, 1'b1);
    put(8'h00, 1'b1);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      put(8'(i + 8'ha0), 1'b1);
    end
    put(8'hee, 1'b0);
    i_ctrl.stop_cond();
    @(negedge clk);
    ram_ready = 1'b1;
    repeat (40) @(negedge clk);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      pop_word(6'(i), 8'(i + 8'ha0));
    end
    check("word count", 16'h0, 16'(words.size()));
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    t_address();
    t_command();
    t_subaddr();
    t_fifo();
    end_sim();
  end
endmodule // tb

// [src/data_fifo.sv]
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module data_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  // Filling side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Draining side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             push;
  logic             pop;

  // Extra pointer bit tells full from empty without a counter
  assign in_ready_o  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
  assign out_valid_o = (wr_ptr != rd_ptr);
  assign out_data_o  = mem[rd_ptr[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Storage; written only on an accepted push
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data_i;
    end
  end

  // Write pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  // Read pointer
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule // data_fifo

// [src/lcd_i2c_pkg.sv]
// Shared constants and types for the LCD driver I2C target front end
package lcd_i2c_pkg;
  // Fixed upper six bits of the target address byte
  localparam logic [5:0] ADDR_FIXED  = 6'h1c;
  // Field positions inside the address byte
  localparam int         ADDR_RW_BIT  = 0;
  localparam int         ADDR_SEL_BIT = 1;
  // Continuation flag position inside a command byte
  localparam int         CMD_CONT_BIT = 7;
  // Bits per byte and the bit count at which the acknowledge slot starts
  localparam int         BYTE_BITS    = 8;
  localparam logic [3:0] ACK_SLOT     = 4'h8;
  // Data pointer and subaddress widths, last pointer location
  localparam int         PTR_W        = 6;
  localparam int         SUB_W        = 3;
  localparam logic [5:0] PTR_LAST     = 6'h27;
  // Reset values of the pointer and the subaddress counter
  localparam logic [5:0] PTR_RST      = 6'h00;
  localparam logic [2:0] SUB_RST      = 3'h0;
  // Depth of the display data buffer
  localparam int         FIFO_DEPTH   = 16;
  // Clock rate of the block
  localparam int         CLK_HZ       = 50_000_000;

  // Transfer phases of the target
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_CMD,
    ST_DATA,
    ST_IGNORE
  } state_t;
endpackage

// [src/lcd_i2c_target.sv]
// Write-only I2C target front end of a segment LCD driver
//
// Notes on behaviour
// - Only the two target addresses 0111000 and 0111001 are answered; all others are ignored.
// - Address bit 1 must equal the strap level and bits 7 to 2 must equal 011100.
// - An address byte asking for a read is neither acknowledged nor answered with data.
// - Each access opens with a START and the address byte, acknowledged by every matching device.
// - A device whose strap does not match ignores the transfer until the next START or STOP.
// - A command byte with its top bit clear is the last; the bytes after it are display data.
// - Every selected device acknowledges each command byte.
// - Display data is written to RAM at the location given by pointer and subaddress.
// - The pointer advances by itself after each display data byte; the subaddress steps when the pointer wraps.
// - In the data phase a byte is acknowledged only if the subaddress equals the pin pattern.
// - Two addresses with a three-bit subaddress let 16 devices share one bus.
// - The data line is driven only to acknowledge; no transfer is started, no data is sent.
// - The three subaddress pins form a binary number, all low meaning subaddress 0.
`timescale 1ns/1ps
module lcd_i2c_target
  import lcd_i2c_pkg::*;
#(
  parameter int                PW       = PTR_W,
  parameter logic [PTR_W-1:0]  PTR_MAX  = PTR_LAST,
  parameter int                BUF_DEPTH = FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             CLK_I,
  input  wire logic             NRST_I,
  // I2C bus pins, open drain data
  input  wire logic             SCL_I,
  input  wire logic             SDA_I,
  output logic                  SDA_O,
  output logic                  SDA_OE_O,
  // Strap and hardware subaddress pins
  input  wire logic             ADDR_SELECT_STRAP_I,
  input  wire logic             HW_SUBADDR_PIN_0_I,
  input  wire logic             HW_SUBADDR_PIN_1_I,
  input  wire logic             HW_SUBADDR_PIN_2_I,
  // Command byte stream to the command decoder
  output logic                  CMD_VALID_O,
  output logic [7:0]            CMD_DATA_O,
  // Pointer loads from the command decoder
  input  wire logic             PTR_LOAD_I,
  input  wire logic [PTR_W-1:0] PTR_VALUE_I,
  input  wire logic             SUB_LOAD_I,
  input  wire logic [SUB_W-1:0] SUB_VALUE_I,
  // Display RAM write port
  output logic                  RAM_VALID_O,
  input  wire logic             RAM_READY_I,
  output logic [PTR_W-1:0]      RAM_ADDR_O,
  output logic [7:0]            RAM_DATA_O
);
  localparam int WW = PTR_W + BYTE_BITS;

  // Synchronisers: first stages are read only by the second stages
  logic [1:0]       scl_sync;
  logic [1:0]       sda_sync;
  logic [1:0]       strap_sync;
  logic [SUB_W-1:0] sub_meta;
  logic [SUB_W-1:0] hw_sub;
  logic             scl_d;
  logic             sda_d;

  logic             scl_s;
  logic             sda_s;
  logic             strap_s;
  logic             scl_rise;
  logic             scl_fall;
  logic             start_det;
  logic             stop_det;

  state_t           state;
  logic [3:0]       bit_cnt;
  logic [7:0]       shreg;
  logic             ack_active;
  logic             sda_oe;
  logic             ack_decide;
  logic             byte_end;
  logic             addr_match;
  logic             next_ack;
  logic [PTR_W-1:0] ptr;
  logic [SUB_W-1:0] sub_cnt;
  logic             fifo_ready;
  logic             fifo_push;
  logic [WW-1:0]    fifo_out;

  // Two flip-flops on every pin before any logic looks at it
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      scl_sync   <= 2'h3;
      sda_sync   <= 2'h3;
      strap_sync <= 2'h0;
      sub_meta   <= '0;
      hw_sub     <= '0;
    end else begin
      scl_sync   <= {scl_sync[0], SCL_I};
      sda_sync   <= {sda_sync[0], SDA_I};
      strap_sync <= {strap_sync[0], ADDR_SELECT_STRAP_I};
      // Pins read as a binary number, pin 0 the low bit
      sub_meta   <= {HW_SUBADDR_PIN_2_I, HW_SUBADDR_PIN_1_I, HW_SUBADDR_PIN_0_I};
      hw_sub     <= sub_meta;
    end
  end

  // Delayed copies of the synchronised lines for edge detection
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_s     = scl_sync[1];
  assign sda_s     = sda_sync[1];
  assign strap_s   = strap_sync[1];
  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  // Data edges while the clock stays high are bus conditions
  assign start_det = scl_s && scl_d && sda_d && !sda_s;
  assign stop_det  = scl_s && scl_d && !sda_d && sda_s;

  // Acknowledge slot opens on the fall after the eighth bit, closes on the next fall
  assign ack_decide = scl_fall && (bit_cnt == ACK_SLOT) && !ack_active;
  assign byte_end   = scl_fall && ack_active;

  // Fixed pattern plus strap bit; two addresses times eight subaddresses give 16 devices
  assign addr_match = (shreg[7:2] == ADDR_FIXED) && (shreg[ADDR_SEL_BIT] == strap_s);

  // Acknowledge decision for the byte just received
  always_comb begin
    next_ack = 1'b0;
    case (state)
      ST_ADDR: next_ack = addr_match && !shreg[ADDR_RW_BIT];
      ST_CMD:  next_ack = 1'b1;
      ST_DATA: next_ack = (sub_cnt == hw_sub) && fifo_ready;
      default: next_ack = 1'b0;
    endcase
  end

  // Bit counter and shift register; START and STOP drop a partial byte
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
    end else if (start_det || stop_det) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise && !ack_active && bit_cnt < ACK_SLOT) begin
      shreg   <= {shreg[6:0], sda_s};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (byte_end) begin
      bit_cnt <= 4'h0;
    end
  end

  // Acknowledge slot tracking and the only drive of the data line
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ack_active <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (start_det || stop_det) begin
      ack_active <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (ack_decide) begin
      ack_active <= 1'b1;
      sda_oe     <= next_ack;
    end else if (byte_end) begin
      ack_active <= 1'b0;
      sda_oe     <= 1'b0;
    end
  end

  // Open drain: the line is only ever pulled low
  assign SDA_O    = 1'b0;
  assign SDA_OE_O = sda_oe;

  // Transfer phase; a mismatch or a read sits in ignore until START or STOP
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state <= ST_IDLE;
    end else if (start_det) begin
      state <= ST_ADDR;
    end else if (stop_det) begin
      state <= ST_IDLE;
    end else if (byte_end) begin
      case (state)
        ST_ADDR: state <= (addr_match && !shreg[ADDR_RW_BIT]) ? ST_CMD : ST_IGNORE;
        ST_CMD:  state <= shreg[CMD_CONT_BIT] ? ST_CMD : ST_DATA;
        default: state <= state;
      endcase
    end
  end

  // Command bytes go to the decoder on the acknowledge decision
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      CMD_VALID_O <= 1'b0;
      CMD_DATA_O  <= 8'h00;
    end else begin
      CMD_VALID_O <= ack_decide && (state == ST_CMD);
      if (ack_decide && (state == ST_CMD)) begin
        CMD_DATA_O <= shreg;
      end
    end
  end

  // Pointer advances after every data byte, even for another device's subaddress
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ptr <= PTR_RST;
    end else if (PTR_LOAD_I) begin
      ptr <= PTR_VALUE_I;
    end else if (byte_end && state == ST_DATA) begin
      ptr <= (ptr == PTR_MAX) ? PTR_RST : ptr + 6'h01;
    end
  end

  // Subaddress steps on pointer wrap so the stream moves to the next cascaded device
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      sub_cnt <= SUB_RST;
    end else if (SUB_LOAD_I) begin
      sub_cnt <= SUB_VALUE_I;
    end else if (byte_end && state == ST_DATA && ptr == PTR_MAX) begin
      sub_cnt <= sub_cnt + 3'h1;
    end
  end

  // A full buffer refuses the byte by withholding the acknowledge
  assign fifo_push = ack_decide && (state == ST_DATA) && (sub_cnt == hw_sub);

  data_fifo #(
    .WIDTH (WW),
    .DEPTH (BUF_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .nrst_i      (NRST_I),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({ptr, shreg}),
    .out_valid_o (RAM_VALID_O),
    .out_ready_i (RAM_READY_I),
    .out_data_o  (fifo_out)
  );

  // Location and data travel together through the buffer
  assign RAM_ADDR_O = fifo_out[WW-1:BYTE_BITS];
  assign RAM_DATA_O = fifo_out[BYTE_BITS-1:0];

  // Checks on the design's own behaviour
  chk_oe_only_ack: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    sda_oe |-> ack_active && bit_cnt == ACK_SLOT)
    else $error("data line driven outside an acknowledge slot");

  chk_read_refused: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ack_decide && state == ST_ADDR && shreg[ADDR_RW_BIT]) |=> !SDA_OE_O)
    else $error("read address acknowledged");

  chk_addr_ack: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ack_decide && state == ST_ADDR && shreg[7:2] == ADDR_FIXED
     && shreg[ADDR_SEL_BIT] == strap_s && !shreg[ADDR_RW_BIT]) |=> SDA_OE_O)
    else $error("own write address not acknowledged");

  chk_addr_foreign: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ack_decide && state == ST_ADDR && (shreg[7:2] != ADDR_FIXED
     || shreg[ADDR_SEL_BIT] != strap_s)) |=> !SDA_OE_O)
    else $error("foreign address acknowledged");

  chk_cmd_ack: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ack_decide && state == ST_CMD) |=> SDA_OE_O && CMD_VALID_O && CMD_DATA_O == $past(shreg))
    else $error("command byte not acknowledged or not passed on");

  chk_data_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (ack_decide && state == ST_DATA && sub_cnt != hw_sub) |=> !SDA_OE_O)
    else $error("data byte acknowledged for another subaddress");

  chk_ptr_step: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (byte_end && state == ST_DATA && !PTR_LOAD_I && ptr != PTR_MAX)
    |=> ptr == $past(ptr) + 6'h01)
    else $error("data pointer did not advance");

  chk_ignore_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state == ST_IGNORE && !start_det && !stop_det) |=> state == ST_IGNORE && !SDA_OE_O)
    else $error("ignored transfer left early");

  chk_start_abort: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    start_det |=> bit_cnt == 4'h0 && state == ST_ADDR && !SDA_OE_O)
    else $error("start did not restart byte reception");

  chk_final_cmd: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (byte_end && state == ST_CMD && !shreg[CMD_CONT_BIT] && !start_det && !stop_det)
    |=> state == ST_DATA)
    else $error("last command byte did not open the data phase");

  cov_addr_ack: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    ack_decide && state == ST_ADDR && next_ack);

  cov_data_phase: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    state == ST_CMD ##1 state == ST_DATA);

  cov_buffer_full: cover property (@(posedge CLK_I) disable iff (!NRST_I)
    fifo_push && !fifo_ready);
endmodule // lcd_i2c_target
